// ===== fbp_flash_gate.sv
// module: flash array with block erase and per-region protection gate
module fbp_flash_gate (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire fbp_pkg::fbp_rd_req_s i_rd,
    input wire fbp_pkg::fbp_wr_req_s i_wr,
    input wire logic [fbp_pkg::NUM_REGIONS-1:0] i_ro_map,
    input wire logic [fbp_pkg::NUM_REGIONS-1:0] i_xo_map,
    input wire logic i_viol_clr,
    output fbp_pkg::fbp_rd_rsp_s o_rd,
    output logic o_busy,
    output logic o_wr_refused,
    output logic o_viol
);
    import fbp_pkg::*;

    typedef enum {ST_IDLE, ST_ERASE} fbp_state_e;

    logic [31:0] mem [NUM_WORDS];
    fbp_state_e state_reg;
    logic [BLK_W-1:0] erase_blk_reg;
    logic [WIB_W-1:0] erase_idx_reg;
    logic rd_ok;
    logic wr_ok;
    logic wr_take;
    logic rd_deny;
    logic wr_deny;
    logic [WADDR_W-1:0] erase_addr;

    fbp_region_guard u_guard (
        .i_ro_map(i_ro_map),
        .i_xo_map(i_xo_map),
        .i_rd_region(i_rd.waddr[WADDR_W-1:REG_LSB]),
        .i_rd_src(i_rd.src),
        .i_wr_region(i_wr.waddr[WADDR_W-1:REG_LSB]),
        .o_rd_ok(rd_ok),
        .o_wr_ok(wr_ok)
    );

    // write requests arriving during an erase are dropped, shown by o_busy; reads are still served
    assign wr_take = i_wr.valid && state_reg == ST_IDLE;
    assign rd_deny = i_rd.valid && !rd_ok;
    assign wr_deny = wr_take && !wr_ok;
    // word being erased, named so checks can look back at it
    assign erase_addr = {erase_blk_reg, erase_idx_reg};

    // array content is not reset, like real flash cells
    always_ff @(posedge i_ref_clk) begin
        if (state_reg == ST_ERASE) begin
            mem[erase_addr] <= ERASED_WORD;
        end else if (wr_take && wr_ok && !i_wr.erase) begin
            // programming only clears bits, as flash does
            mem[i_wr.waddr] <= mem[i_wr.waddr] & i_wr.wdata;
        end
    end

    // erase walks one word a cycle inside one 1 KB block only
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            state_reg <= ST_IDLE;
            erase_blk_reg <= '0;
            erase_idx_reg <= '0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (wr_take && wr_ok && i_wr.erase) begin
                        state_reg <= ST_ERASE;
                        erase_blk_reg <= i_wr.waddr[WADDR_W-1:BLK_LSB];
                        erase_idx_reg <= '0;
                    end
                end
                ST_ERASE: begin
                    erase_idx_reg <= erase_idx_reg + 1'b1;
                    if (erase_idx_reg == LAST_WIB) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // busy is a flop fed from the next state, so it matches ST_ERASE in every cycle
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_busy <= 1'b0;
        end else begin
            o_busy <= (state_reg == ST_IDLE) ? (wr_take && wr_ok && i_wr.erase)
                                             : (erase_idx_reg != LAST_WIB);
        end
    end

    // read answer one edge after the request, no wait states
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_rd <= '0;
        end else begin
            o_rd.valid <= i_rd.valid;
            o_rd.denied <= rd_deny;
            if (!i_rd.valid) begin
                o_rd.rdata <= '0;
            end else if (rd_ok) begin
                o_rd.rdata <= mem[i_rd.waddr];
            end else begin
                o_rd.rdata <= DENIED_WORD;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_wr_refused <= 1'b0;
        end else begin
            o_wr_refused <= wr_deny;
        end
    end

    // set beats clear so a refusal in the clear cycle is kept
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_viol <= 1'b0;
        end else if (rd_deny || wr_deny) begin
            o_viol <= 1'b1;
        end else if (i_viol_clr) begin
            o_viol <= 1'b0;
        end
    end

    a_read_one_cycle: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        i_rd.valid |=> o_rd.valid)
        else $error("read answer not one cycle later");

    a_xo_data_denied: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_rd.valid && i_xo_map[i_rd.waddr[WADDR_W-1:REG_LSB]] && i_rd.src != FBP_SRC_FETCH)
        |=> (o_rd.denied && o_rd.rdata == DENIED_WORD))
        else $error("non-fetch read of execute-only region served");

    a_xo_fetch_ok: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_rd.valid && i_rd.src == FBP_SRC_FETCH) |=> !o_rd.denied)
        else $error("fetch denied");

    a_ro_refused: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (wr_take && i_ro_map[i_wr.waddr[WADDR_W-1:REG_LSB]]) |=> (o_wr_refused && o_viol))
        else $error("write to read-only region not refused");

    a_xo_no_erase: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (wr_take && i_wr.erase && i_xo_map[i_wr.waddr[WADDR_W-1:REG_LSB]]) |=> !o_busy)
        else $error("erase of execute-only region started");

    a_erase_length: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        $rose(o_busy) |-> o_busy [*8])
        else $error("erase ended too early");

    a_erase_ends: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        $rose(o_busy) |-> ##[256:257] !o_busy)
        else $error("erase did not finish in time");

    a_viol_sticky: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (o_viol && !i_viol_clr) |=> o_viol)
        else $error("violation flag dropped without clear");

    a_refused_only_deny: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        !wr_deny |=> !o_wr_refused)
        else $error("refusal pulse without a refused request");

    a_xo_prog_refused: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (wr_take && i_xo_map[i_wr.waddr[WADDR_W-1:REG_LSB]]) |=> (o_wr_refused && o_viol))
        else $error("change to execute-only region not refused");

    a_ro_no_erase: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (wr_take && i_wr.erase && i_ro_map[i_wr.waddr[WADDR_W-1:REG_LSB]]) |=> !o_busy)
        else $error("erase of read-only region started");

    a_ok_erase_starts: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (wr_take && wr_ok && i_wr.erase) |=> o_busy)
        else $error("permitted erase did not start");

    a_erase_one_block: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (state_reg == ST_ERASE && erase_idx_reg != LAST_WIB)
        |=> (state_reg == ST_ERASE && $stable(erase_blk_reg)))
        else $error("erase left its block early");

    a_erase_fills_ones: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (state_reg == ST_ERASE) |=> (mem[$past(erase_addr)] == ERASED_WORD))
        else $error("erased word not all ones");

    a_ro_read_allowed: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_rd.valid && !i_xo_map[i_rd.waddr[WADDR_W-1:REG_LSB]]) |=> !o_rd.denied)
        else $error("read outside execute-only region denied");

    a_rd_idle_zero: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        !i_rd.valid |=> (!o_rd.valid && o_rd.rdata == 32'h00000000))
        else $error("read answer without a request");

    a_viol_set_wins: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (rd_deny || wr_deny) |=> o_viol)
        else $error("refusal did not set violation flag");

    a_viol_needs_event: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (!o_viol && !rd_deny && !wr_deny) |=> !o_viol)
        else $error("violation flag set without refusal");
endmodule

// ===== fbp_pkg.sv
// package: constants and carriers for the flash block protection gate
// Operation
// - 128 KB array, 1 KB blocks erased alone
// - erased block reads all ones
// - protection held per 2 KB region
// - read-only region refuses erase and program
// - execute-only region refuses erase and program
// - execute-only region readable by fetch only
// - permitted reads finish in one cycle
package fbp_pkg;
    localparam int FLASH_BYTES = 131072;
    localparam int WORD_BYTES = 4;
    localparam int BLOCK_BYTES = 1024;
    localparam int REGION_BYTES = 2048;
    localparam int NUM_WORDS = FLASH_BYTES / WORD_BYTES;
    localparam int NUM_BLOCKS = FLASH_BYTES / BLOCK_BYTES;
    localparam int NUM_REGIONS = FLASH_BYTES / REGION_BYTES;
    localparam int WADDR_W = 15;
    localparam int BLK_W = 7;
    localparam int REG_W = 6;
    localparam int WORDS_PER_BLOCK = BLOCK_BYTES / WORD_BYTES;
    localparam int WIB_W = 8;
    localparam int BLK_LSB = 8;
    localparam int REG_LSB = 9;
    localparam logic [31:0] ERASED_WORD = 32'hFFFFFFFF;
    localparam logic [31:0] DENIED_WORD = 32'h00000000;
    localparam logic [WIB_W-1:0] LAST_WIB = 8'hFF;

    typedef enum logic [1:0] {FBP_SRC_FETCH, FBP_SRC_DATA, FBP_SRC_DEBUG} fbp_src_e;

    typedef struct packed {
        logic valid;
        fbp_src_e src;
        logic [WADDR_W-1:0] waddr;
    } fbp_rd_req_s;

    typedef struct packed {
        logic valid;
        logic erase;
        logic [WADDR_W-1:0] waddr;
        logic [31:0] wdata;
    } fbp_wr_req_s;

    typedef struct packed {
        logic valid;
        logic denied;
        logic [31:0] rdata;
    } fbp_rd_rsp_s;
endpackage

// ===== fbp_region_guard.sv
// module: protection decision for one read and one modify request
module fbp_region_guard (
    input wire logic [fbp_pkg::NUM_REGIONS-1:0] i_ro_map,
    input wire logic [fbp_pkg::NUM_REGIONS-1:0] i_xo_map,
    input wire logic [fbp_pkg::REG_W-1:0] i_rd_region,
    input wire fbp_pkg::fbp_src_e i_rd_src,
    input wire logic [fbp_pkg::REG_W-1:0] i_wr_region,
    output logic o_rd_ok,
    output logic o_wr_ok
);
    import fbp_pkg::*;
    // either protection kind locks the region against change
    assign o_wr_ok = !(i_ro_map[i_wr_region] || i_xo_map[i_wr_region]);
    // execute-only regions serve instruction fetch alone
    assign o_rd_ok = !i_xo_map[i_rd_region] || (i_rd_src == FBP_SRC_FETCH);
endmodule

// ===== fbp_far_side.sv
// reader model standing for the fetch, data and debug paths
module fbp_far_side (
    input wire logic i_ref_clk,
    input wire logic i_go,
    input wire fbp_pkg::fbp_src_e i_src,
    input wire logic [fbp_pkg::WADDR_W-1:0] i_waddr,
    input wire fbp_pkg::fbp_rd_rsp_s i_rsp,
    output fbp_pkg::fbp_rd_req_s o_req,
    output fbp_pkg::fbp_rd_rsp_s o_got,
    output logic o_late
);
    import fbp_pkg::*;
    logic pend_reg;
    always_ff @(posedge i_ref_clk) begin
        o_req.valid <= i_go;
        o_req.src <= i_src;
        // a released address flips, so stale values never look held
        o_req.waddr <= i_go ? i_waddr : ~o_req.waddr;
        pend_reg <= o_req.valid;
        if (pend_reg) begin
            o_got <= i_rsp;
            o_late <= !i_rsp.valid;
        end
    end
endmodule

// ===== tb_top.sv
// testbench for the flash protection gate
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import fbp_pkg::*;
    logic i_ref_clk = 0;
    logic i_sys_rst = 1;
    logic i_viol_clr = 0;
    logic go = 0;
    logic o_busy, o_wr_refused, o_viol, late;
    logic [63:0] ro = '0;
    logic [63:0] xo = '0;
    fbp_src_e src = FBP_SRC_FETCH;
    logic [14:0] adr = '0;
    fbp_wr_req_s wr = '0;
    fbp_rd_req_s rq;
    fbp_rd_rsp_s rsp, got;
    int n_errors = 0;
    int total_checks = 0;
    initial begin
        forever #10 i_ref_clk = ~i_ref_clk;
    end
    fbp_flash_gate uut (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_rd(rq), .i_wr(wr),
        .i_ro_map(ro), .i_xo_map(xo), .i_viol_clr(i_viol_clr), .o_rd(rsp), .o_busy(o_busy),
        .o_wr_refused(o_wr_refused), .o_viol(o_viol));
    fbp_far_side fs (.i_ref_clk(i_ref_clk), .i_go(go), .i_src(src), .i_waddr(adr),
        .i_rsp(rsp), .o_req(rq), .o_got(got), .o_late(late));
    task automatic results;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rd(input fbp_src_e s, input logic [14:0] a, input logic [31:0] e,
        input logic dn);
        @(posedge i_ref_clk);
        go <= 1'b1;
        src <= s;
        adr <= a;
        @(posedge i_ref_clk);
        go <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        #1;
        chk(got.rdata, e);
        chk({31'h0, got.denied}, {31'h0, dn});
        chk({31'h0, late}, 32'h0);
        chk({31'h0, o_viol}, {31'h0, dn});
    endtask
    task automatic wr_op(input logic er, input logic [14:0] a, input logic [31:0] d,
        input logic rf);
        int n;
        @(posedge i_ref_clk);
        wr <= '{1'b1, er, a, d};
        @(posedge i_ref_clk);
        wr.valid <= 1'b0;
        #1;
        chk({31'h0, o_wr_refused}, {31'h0, rf});
        chk({31'h0, o_viol}, {31'h0, rf});
        n = 0;
        while (o_busy === 1'b1 && n < 300) begin
            @(posedge i_ref_clk);
            #1;
            n++;
        end
        chk(n, (er && !rf) ? 256 : 0);
        if (n >= 300) results();
        // sticky flag is cleared so the next step starts clean
        @(posedge i_ref_clk);
        i_viol_clr <= 1'b1;
        @(posedge i_ref_clk);
        i_viol_clr <= 1'b0;
    endtask
    // denied read meets a clear in the same cycle: the set must win
    task automatic viol_race;
        @(posedge i_ref_clk);
        go <= 1'b1;
        src <= FBP_SRC_DATA;
        adr <= 15'h0101;
        @(posedge i_ref_clk);
        go <= 1'b0;
        i_viol_clr <= 1'b1;
        @(posedge i_ref_clk);
        i_viol_clr <= 1'b0;
        @(posedge i_ref_clk);
        #1;
        chk({31'h0, o_viol}, 32'h1);
        @(posedge i_ref_clk);
        i_viol_clr <= 1'b1;
        @(posedge i_ref_clk);
        i_viol_clr <= 1'b0;
        #1;
        chk({31'h0, o_viol}, 32'h0);
    endtask
    initial begin
        repeat (2) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        wr_op(1'b1, 15'h0000, 32'h0, 1'b0);
        wr_op(1'b1, 15'h0100, 32'h0, 1'b0);
        wr_op(1'b0, 15'h0101, 32'h1234ABCD, 1'b0);
        wr_op(1'b0, 15'h0001, 32'h0F0F0F0F, 1'b0);
        rd(FBP_SRC_DEBUG, 15'h0001, 32'h0F0F0F0F, 1'b0);
        wr_op(1'b1, 15'h0000, 32'h0, 1'b0);
        rd(FBP_SRC_DATA, 15'h0001, ERASED_WORD, 1'b0);
        rd(FBP_SRC_FETCH, 15'h00FF, ERASED_WORD, 1'b0);
        rd(FBP_SRC_DATA, 15'h0101, 32'h1234ABCD, 1'b0);
        @(posedge i_ref_clk);
        ro <= 64'h1;
        wr_op(1'b0, 15'h0001, 32'h0, 1'b1);
        wr_op(1'b1, 15'h0100, 32'h0, 1'b1);
        rd(FBP_SRC_DATA, 15'h0001, ERASED_WORD, 1'b0);
        wr_op(1'b1, 15'h0200, 32'h0, 1'b0);
        @(posedge i_ref_clk);
        ro <= 64'h0;
        xo <= 64'h1;
        wr_op(1'b1, 15'h0000, 32'h0, 1'b1);
        wr_op(1'b0, 15'h01FF, 32'h0, 1'b1);
        rd(FBP_SRC_DATA, 15'h0101, DENIED_WORD, 1'b1);
        rd(FBP_SRC_DEBUG, 15'h0101, DENIED_WORD, 1'b1);
        wr_op(1'b0, 15'h0000, 32'hFFFFFFFF, 1'b1);
        viol_race();
        rd(FBP_SRC_FETCH, 15'h0101, 32'h1234ABCD, 1'b0);
        results();
    end
endmodule
